//--- logic/sbrg_pkg.sv
// Package for the serial baud rate generator: map, fields, constants
package sbrg_pkg;
    // Register byte offsets on the APB bus
    localparam logic [7:0] SBRG_OFF_BAUD_CONTROL = 8'h00;
    localparam logic [7:0] SBRG_OFF_TRANSMIT_CONTROL = 8'h04;
    localparam logic [7:0] SBRG_OFF_RECEIVE_CONTROL = 8'h08;
    localparam logic [7:0] SBRG_OFF_RATE_DIVISOR_HIGH = 8'h0c;
    localparam logic [7:0] SBRG_OFF_RATE_DIVISOR_LOW = 8'h10;

    // Baud control field positions
    localparam int SBRG_BC_AUTOBAUD_OVERFLOW = 7;
    localparam int SBRG_BC_RECEIVER_IDLE = 6;
    localparam int SBRG_BC_RECEIVE_POLARITY = 5;
    localparam int SBRG_BC_TRANSMIT_POLARITY = 4;
    localparam int SBRG_BC_WIDE_COUNTER = 3;
    localparam int SBRG_BC_UNUSED = 2;
    localparam int SBRG_BC_WAKEUP_ENABLE = 1;
    localparam int SBRG_BC_AUTOBAUD_ENABLE = 0;

    // Transmit control field positions
    localparam int SBRG_TC_MODE_SYNC = 4;
    localparam int SBRG_TC_HIGH_SPEED = 2;
    localparam int SBRG_TC_SHIFT_EMPTY = 1;

    // Receive control: status bits come from the receiver
    localparam int SBRG_RC_STATUS_W = 3;

    // Reset values
    localparam logic [7:0] SBRG_RST_BAUD_CONTROL = 8'h00;
    localparam logic [7:0] SBRG_RST_TRANSMIT_CONTROL = 8'h00;
    localparam logic [7:0] SBRG_RST_RECEIVE_CONTROL = 8'h00;
    localparam logic [7:0] SBRG_RST_DIVISOR = 8'h00;

    // Clocks per divisor step, by mode
    localparam int SBRG_PRE_W = 7;
    localparam logic [6:0] SBRG_PRE_ASYNC_NARROW_LOW = 7'h40;
    localparam logic [6:0] SBRG_PRE_ASYNC_WIDE_LOW = 7'h10;
    localparam logic [6:0] SBRG_PRE_ASYNC_NARROW_HIGH = 7'h10;
    localparam logic [6:0] SBRG_PRE_ASYNC_WIDE_HIGH = 7'h04;
    localparam logic [6:0] SBRG_PRE_SYNC = 7'h04;
    localparam logic [6:0] SBRG_PRE_ONE = 7'h01;
    localparam logic [15:0] SBRG_DIV_ONE = 16'h0001;
endpackage

//--- logic/sbrg_top.sv
// Baud rate generator with baud control registers behind an APB slave
// Notes on behaviour
// - Timer narrow after reset, wide when selected
// - Divisor sets period; sync ignores high speed
// - Divisor byte write clears the timer
// - Async narrow low speed: clock/(64(n+1))
// - Async wide low speed: clock/(16(n+1))
// - Sync mode: clock/(4(n+1)), any width
// - Bit 7 reads auto-baud overflow
// - Bit 6 reads receiver idle state
// - Bit 5 inverts incoming receive/data line
// - Async bit 4 sets transmit idle level
// - Sync bit 4 picks change/sample clock edges
// - Bit 3 uses both divisor bytes
// - Bit 2 always reads zero
// - Wake-up: falling edge flags, rising clears
// - Auto-baud enable starts, hardware clears it
// - Mode bit selects synchronous operation
// - High speed bit used only async
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module sbrg_top
    import sbrg_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // APB slave
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Receive pin and receiver status
    input wire logic rx_pin_in,
    input wire logic receiver_idle_in,
    input wire logic [2:0] receive_status_in,
    input wire logic autobaud_done_in,
    input wire logic autobaud_overflow_in,
    // Transmitter status and data
    input wire logic shift_empty_in,
    input wire logic tx_busy_in,
    input wire logic tx_bit_in,
    // Rate and serial outputs
    output logic baud_tick_out,
    output logic rx_data_out,
    output logic tx_line_out,
    output logic sync_clk_out,
    output logic data_change_out,
    output logic data_sample_out,
    // Receiver controls
    output logic receive_interrupt_flag_out,
    output logic autobaud_active_out,
    output logic wakeup_active_out,
    output logic sync_mode_out
);
    // Register storage
    logic [7:0] baud_control_q;
    logic [7:0] transmit_control_q;
    logic [7:0] receive_control_q;
    logic [7:0] rate_divisor_high_q;
    logic [7:0] rate_divisor_low_q;
    logic autobaud_overflow_q;
    // Timer state
    logic [SBRG_PRE_W-1:0] prescale_q;
    logic [15:0] divider_q;
    logic tick_q;
    // Receive line synchroniser and edge history
    logic rx_meta_q;
    logic rx_sync_q;
    logic rx_prev_q;
    logic wake_seen_fall_q;
    logic wake_flag_q;
    // Synchronous clock generation and read data register
    logic sync_phase_q;
    logic change_q;
    logic sample_q;
    logic [31:0] prdata_q;

    // Decoded controls
    logic sync_mode;
    logic high_speed;
    logic wide_counter;
    logic rx_polarity;
    logic tx_polarity;
    logic wakeup_enable;
    logic autobaud_enable;
    logic [15:0] divisor;
    logic [SBRG_PRE_W-1:0] prescale_limit;
    logic apb_write;
    logic apb_read;
    logic divisor_write;
    logic rx_level;
    logic rx_fall;
    logic rx_rise;

    // Address match used by both read and write paths
    function automatic logic sbrg_hit(input logic [7:0] addr,
                                      input logic [7:0] off);
        sbrg_hit = (addr == off);
    endfunction

    function automatic logic sbrg_mapped(input logic [7:0] addr);
        sbrg_mapped = sbrg_hit(addr, SBRG_OFF_BAUD_CONTROL)
            || sbrg_hit(addr, SBRG_OFF_TRANSMIT_CONTROL)
            || sbrg_hit(addr, SBRG_OFF_RECEIVE_CONTROL)
            || sbrg_hit(addr, SBRG_OFF_RATE_DIVISOR_HIGH)
            || sbrg_hit(addr, SBRG_OFF_RATE_DIVISOR_LOW);
    endfunction

    // Field taps
    assign sync_mode = transmit_control_q[SBRG_TC_MODE_SYNC];
    assign high_speed = transmit_control_q[SBRG_TC_HIGH_SPEED];
    assign wide_counter = baud_control_q[SBRG_BC_WIDE_COUNTER];
    assign rx_polarity = baud_control_q[SBRG_BC_RECEIVE_POLARITY];
    assign tx_polarity = baud_control_q[SBRG_BC_TRANSMIT_POLARITY];
    assign wakeup_enable = baud_control_q[SBRG_BC_WAKEUP_ENABLE];
    assign autobaud_enable = baud_control_q[SBRG_BC_AUTOBAUD_ENABLE];

    // APB strobes; zero wait state, so every access completes at once
    assign apb_write = psel_in && penable_in && pwrite_in;
    assign apb_read = psel_in && !pwrite_in;
    assign divisor_write = apb_write
        && (sbrg_hit(paddr_in, SBRG_OFF_RATE_DIVISOR_HIGH)
        || sbrg_hit(paddr_in, SBRG_OFF_RATE_DIVISOR_LOW));
    assign pready_out = 1'b1;
    assign pslverr_out = psel_in && penable_in && !sbrg_mapped(paddr_in);

    // Divisor width follows the wide counter select
    always_comb begin
        if (wide_counter) begin
            divisor = {rate_divisor_high_q, rate_divisor_low_q};
        end else begin
            divisor = {8'h00, rate_divisor_low_q};
        end
    end

    // Clocks per divisor step by mode
    always_comb begin
        if (sync_mode) begin
            prescale_limit = SBRG_PRE_SYNC;
        end else if (high_speed) begin
            if (wide_counter) begin
                prescale_limit = SBRG_PRE_ASYNC_WIDE_HIGH;
            end else begin
                prescale_limit = SBRG_PRE_ASYNC_NARROW_HIGH;
            end
        end else if (wide_counter) begin
            prescale_limit = SBRG_PRE_ASYNC_WIDE_LOW;
        end else begin
            prescale_limit = SBRG_PRE_ASYNC_NARROW_LOW;
        end
    end

    // Baud control register; hardware clears win over software sets
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            baud_control_q <= SBRG_RST_BAUD_CONTROL;
        end else begin
            if (apb_write && sbrg_hit(paddr_in, SBRG_OFF_BAUD_CONTROL)) begin
                baud_control_q <= pwdata_in[7:0];
                baud_control_q[SBRG_BC_UNUSED] <= 1'b0;
            end
            // Wake-up ends on the rising edge after the falling one
            if (wakeup_enable && !sync_mode && wake_seen_fall_q
                    && rx_rise) begin
                baud_control_q[SBRG_BC_WAKEUP_ENABLE] <= 1'b0;
            end
            if (autobaud_enable && autobaud_done_in) begin
                baud_control_q[SBRG_BC_AUTOBAUD_ENABLE] <= 1'b0;
            end
        end
    end

    // Overflow flag: set by the measurement, cleared by writing zero
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            autobaud_overflow_q <= 1'b0;
        end else if (autobaud_overflow_in && !sync_mode) begin
            autobaud_overflow_q <= 1'b1;
        end else if (apb_write
                && sbrg_hit(paddr_in, SBRG_OFF_BAUD_CONTROL)) begin
            autobaud_overflow_q <= pwdata_in[SBRG_BC_AUTOBAUD_OVERFLOW];
        end
    end

    // Transmit and receive control storage
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            transmit_control_q <= SBRG_RST_TRANSMIT_CONTROL;
            receive_control_q <= SBRG_RST_RECEIVE_CONTROL;
        end else begin
            if (apb_write
                    && sbrg_hit(paddr_in, SBRG_OFF_TRANSMIT_CONTROL)) begin
                transmit_control_q <= pwdata_in[7:0];
            end
            if (apb_write
                    && sbrg_hit(paddr_in, SBRG_OFF_RECEIVE_CONTROL)) begin
                receive_control_q <= pwdata_in[7:0];
            end
        end
    end

    // Divisor pair
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rate_divisor_high_q <= SBRG_RST_DIVISOR;
            rate_divisor_low_q <= SBRG_RST_DIVISOR;
        end else begin
            if (apb_write
                    && sbrg_hit(paddr_in, SBRG_OFF_RATE_DIVISOR_HIGH)) begin
                rate_divisor_high_q <= pwdata_in[7:0];
            end
            if (apb_write
                    && sbrg_hit(paddr_in, SBRG_OFF_RATE_DIVISOR_LOW)) begin
                rate_divisor_low_q <= pwdata_in[7:0];
            end
        end
    end

    // Free-running timer: prescaler steps the divider, divider wraps at n.
    // Compares use >= so a mode change mid-period cannot overrun.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || divisor_write) begin
            prescale_q <= '0;
            divider_q <= '0;
            tick_q <= 1'b0;
        end else if (prescale_q + SBRG_PRE_ONE >= prescale_limit) begin
            prescale_q <= '0;
            if (divider_q >= divisor) begin
                divider_q <= '0;
                tick_q <= 1'b1;
            end else begin
                divider_q <= divider_q + SBRG_DIV_ONE;
                tick_q <= 1'b0;
            end
        end else begin
            prescale_q <= prescale_q + SBRG_PRE_ONE;
            tick_q <= 1'b0;
        end
    end
    assign baud_tick_out = tick_q;

    // Two-stage synchroniser on the receive pin
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rx_meta_q <= 1'b1;
            rx_sync_q <= 1'b1;
        end else begin
            rx_meta_q <= rx_pin_in;
            rx_sync_q <= rx_meta_q;
        end
    end

    // Polarity applied after the synchroniser
    assign rx_level = rx_sync_q ^ rx_polarity;
    assign rx_fall = rx_prev_q && !rx_level;
    assign rx_rise = !rx_prev_q && rx_level;

    // Edge history and wake-up sequencing
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rx_prev_q <= 1'b1;
            wake_seen_fall_q <= 1'b0;
            wake_flag_q <= 1'b0;
        end else begin
            rx_prev_q <= rx_level;
            wake_flag_q <= 1'b0;
            if (!wakeup_enable || sync_mode) begin
                wake_seen_fall_q <= 1'b0;
            end else if (rx_fall) begin
                wake_seen_fall_q <= 1'b1;
                wake_flag_q <= 1'b1;
            end else if (rx_rise) begin
                wake_seen_fall_q <= 1'b0;
            end
        end
    end

    // Synchronous clock: each tick is a half period
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sync_phase_q <= 1'b0;
            change_q <= 1'b0;
            sample_q <= 1'b0;
        end else if (sync_mode && tick_q) begin
            sync_phase_q <= !sync_phase_q;
            // Change on the falling edge (phase was high) when polarity is one, on the rising edge when zero
            change_q <= (sync_phase_q == tx_polarity);
            sample_q <= (sync_phase_q != tx_polarity);
        end else begin
            if (!sync_mode) begin
                sync_phase_q <= 1'b0;
            end
            change_q <= 1'b0;
            sample_q <= 1'b0;
        end
    end

    // Transmit line: idle level from polarity in async mode
    always_comb begin
        if (sync_mode) begin
            tx_line_out = sync_phase_q;
        end else if (tx_busy_in) begin
            tx_line_out = tx_bit_in ^ tx_polarity;
        end else begin
            tx_line_out = !tx_polarity;
        end
    end

    // Read mux, registered in the setup cycle
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            prdata_q <= '0;
        end else if (apb_read && !penable_in) begin
            prdata_q <= '0;
            if (sbrg_hit(paddr_in, SBRG_OFF_BAUD_CONTROL)) begin
                prdata_q[7:0] <= {autobaud_overflow_q,
                    receiver_idle_in,
                    rx_polarity, tx_polarity, wide_counter,
                    1'b0,
                    wakeup_enable, autobaud_enable};
            end else if (sbrg_hit(paddr_in, SBRG_OFF_TRANSMIT_CONTROL)) begin
                prdata_q[7:0] <= transmit_control_q;
                prdata_q[SBRG_TC_SHIFT_EMPTY] <= shift_empty_in;
            end else if (sbrg_hit(paddr_in, SBRG_OFF_RECEIVE_CONTROL)) begin
                prdata_q[7:0] <= {receive_control_q[7:SBRG_RC_STATUS_W],
                    receive_status_in};
            end else if (sbrg_hit(paddr_in, SBRG_OFF_RATE_DIVISOR_HIGH)) begin
                prdata_q[7:0] <= rate_divisor_high_q;
            end else if (sbrg_hit(paddr_in, SBRG_OFF_RATE_DIVISOR_LOW)) begin
                prdata_q[7:0] <= rate_divisor_low_q;
            end
        end
    end

    // Output assignments
    assign prdata_out = prdata_q;
    assign rx_data_out = rx_sync_q ^ rx_polarity;
    assign sync_clk_out = sync_phase_q;
    assign data_change_out = change_q;
    assign data_sample_out = sample_q;
    assign receive_interrupt_flag_out = wake_flag_q;
    // Auto-baud has no effect in synchronous mode
    assign autobaud_active_out = autobaud_enable && !sync_mode;
    assign wakeup_active_out = wakeup_enable && !sync_mode;
    assign sync_mode_out = sync_mode;
endmodule
`default_nettype wire

//--- tb/sbrg_chk.sv
// Port checker for the baud rate generator, bound to its top
`timescale 1ns/100ps
`default_nettype none
module sbrg_chk (
    // Clock, reset and bus
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    input wire logic [31:0] prdata_out,
    // Line side and status
    input wire logic rx_pin_in,
    input wire logic tx_busy_in,
    input wire logic autobaud_done_in,
    input wire logic baud_tick_out,
    input wire logic rx_data_out,
    input wire logic tx_line_out,
    input wire logic sync_clk_out,
    input wire logic data_change_out,
    input wire logic data_sample_out,
    input wire logic receive_interrupt_flag_out,
    input wire logic autobaud_active_out,
    input wire logic wakeup_active_out,
    input wire logic sync_mode_out
);
    logic [1:0] pol_q;
    logic acc;
    assign acc = psel_in && penable_in;
    // Polarity shadow; only software changes these two bits
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pol_q <= 2'h0;
        end else if (acc && pwrite_in && paddr_in == 8'h00) begin
            pol_q <= pwdata_in[5:4];
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    tick_pulse_a: assert property (
        baud_tick_out |=> !baud_tick_out) else $error("tick too long");
    // The write edge forces the tick low; the check still skips one cycle
    div_clear_a: assert property (
        acc && pwrite_in && paddr_in inside {8'h0c, 8'h10}
        |-> ##2 !baud_tick_out [*2]) else $error("timer not cleared");
    rx_pol_a: assert property (
        rx_data_out == ($past(rx_pin_in, 2) ^ pol_q[1]))
        else $error("receive polarity wrong");
    tx_idle_a: assert property (
        !sync_mode_out && !tx_busy_in |-> tx_line_out == !pol_q[0])
        else $error("transmit idle level wrong");
    bit2_zero_a: assert property (
        acc && !pwrite_in && paddr_in == 8'h00 |-> !prdata_out[2])
        else $error("unused bit reads one");
    wake_flag_a: assert property (
        receive_interrupt_flag_out |-> $past(wakeup_active_out)
        ##1 !receive_interrupt_flag_out) else $error("wake flag wrong");
    abd_clear_a: assert property (
        autobaud_done_in && autobaud_active_out |=> !autobaud_active_out)
        else $error("auto-baud enable not cleared");
    change_edge_a: assert property (
        data_change_out |-> sync_clk_out == !pol_q[0])
        else $error("data change on wrong edge");
    sample_edge_a: assert property (
        data_sample_out |-> sync_clk_out == pol_q[0])
        else $error("data sample on wrong edge");
    cover property (receive_interrupt_flag_out);
    cover property (data_change_out ##[1:300] data_sample_out);
    cover property (autobaud_done_in && autobaud_active_out);
endmodule
bind sbrg_top sbrg_chk chk (.*);
`default_nettype wire

//--- tb/sbrg_peer.sv
// Remote transceiver model that drives the receive line
`timescale 1ns/100ps
`default_nettype none
module sbrg_peer (
    // Clock and commands from the bench
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic go_in,
    input wire logic inv_in,
    // Line towards the device
    output logic rx_out
);
    logic [3:0] low_q;
    // Start of a frame: a low span, then back to mark
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            low_q <= 4'h0;
        end else if (go_in) begin
            low_q <= 4'h9;
        end else if (low_q != 4'h0) begin
            low_q <= low_q - 4'h1;
        end
    end
    // Mark level flips where the device expects inverted data
    assign rx_out = inv_in ^ (low_q == 4'h0);
endmodule
`default_nettype wire

//--- tb/testbench.sv
// Self-checking bench for the baud rate generator
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk_in, sys_rst_in, psel_in, penable_in, pwrite_in;
    logic [7:0] paddr_in;
    logic [31:0] pwdata_in, prdata_out, rd;
    logic pready_out, pslverr_out, rx_pin_in, receiver_idle_in, err;
    logic [2:0] receive_status_in;
    logic autobaud_done_in, autobaud_overflow_in, shift_empty_in;
    logic tx_busy_in, tx_bit_in, baud_tick_out, rx_data_out, tx_line_out;
    logic sync_clk_out, data_change_out, data_sample_out, go, inv;
    logic receive_interrupt_flag_out, autobaud_active_out;
    logic wakeup_active_out, sync_mode_out;
    int mismatches, comparisons, flags;
    sbrg_top dut (.*);
    sbrg_peer peer (.clk_in(clk_in), .rst_in(sys_rst_in), .go_in(go),
        .inv_in(inv), .rx_out(rx_pin_in));
    // Clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // Transmitter activity varies freely under every mode
    always @(posedge clk_in) begin
        tx_busy_in <= 1'($urandom_range(0, 1));
        tx_bit_in <= 1'($urandom_range(0, 1));
    end
    // Wake pulses seen at the settled half of the cycle
    always @(negedge clk_in) if (receive_interrupt_flag_out === 1'b1) flags++;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; holds the request until pready is seen
    task automatic apb(input logic [7:0] a, input logic w,
        input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 16);
        if (n == 16) mismatches++;
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(a, 1'b0, 32'h0);
        chk(rd, e);
    endtask
    // Cycles until the next tick, bounded
    task automatic wait_tick(output int c);
        c = 0;
        do begin
            @(negedge clk_in);
            c++;
        end while (baud_tick_out !== 1'b1 && c < 9000);
    endtask
    // Expected period from mode and divisor bytes
    function automatic int period(logic s, w, h, logic [7:0] hi, lo);
        int p;
        p = s ? 4 : w ? (h ? 4 : 16) : (h ? 16 : 64);
        return p * ((w ? int'(hi) * 256 : 0) + int'(lo) + 1);
    endfunction
    // Mode goes async first so polarity never moves under a live clock
    task automatic rate(input logic s, w, h, p);
        logic [7:0] hi, lo;
        int e, c;
        hi = 8'($urandom_range(0, 1));
        lo = 8'($urandom_range(0, 7));
        e = period(s, w, h, hi, lo);
        apb(8'h04, 1'b1, 32'h0);
        apb(8'h00, 1'b1, {27'h0, p, w, 3'h0});
        apb(8'h04, 1'b1, {27'h0, s, 1'b0, h, 2'h0});
        apb(8'h0c, 1'b1, {24'h0, hi});
        apb(8'h10, 1'b1, {24'h0, lo});
        wait_tick(c);
        chk(32'(c - e) & ~32'h1, 32'h0);
        wait_tick(c);
        chk(32'(c), 32'(e));
    endtask
    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        void'($urandom(32'h4d8b4c83));
        {psel_in, penable_in, pwrite_in, go, inv} = 5'h0;
        {autobaud_done_in, autobaud_overflow_in} = 2'h0;
        {receiver_idle_in, shift_empty_in, sys_rst_in} = 3'h7;
        {paddr_in, pwdata_in} = 40'h0;
        {tx_busy_in, tx_bit_in} = 2'h0;
        receive_status_in = 3'($urandom_range(0, 7));
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rdchk(8'h00, 32'h40);
        rdchk(8'h04, 32'h02);
        rdchk(8'h08, {29'h0, receive_status_in});
        rdchk(8'h0c, 32'h0);
        rdchk(8'h10, 32'h0);
        apb(8'h14, 1'b1, 32'hff);
        chk({31'h0, err}, 32'h1);
        rdchk(8'h14, 32'h0);
        // Read-only and unused bits ignore writes; line idles inverted
        receiver_idle_in <= 1'b0;
        inv <= 1'b1;
        apb(8'h00, 1'b1, 32'h7c);
        rdchk(8'h00, 32'h38);
        @(posedge clk_in) go <= 1'b1;
        @(posedge clk_in) go <= 1'b0;
        apb(8'h00, 1'b1, 32'h0);
        inv <= 1'b0;
        receiver_idle_in <= 1'b1;
        @(posedge clk_in) autobaud_overflow_in <= 1'b1;
        @(posedge clk_in) autobaud_overflow_in <= 1'b0;
        rdchk(8'h00, 32'hc0);
        apb(8'h00, 1'b1, 32'h1);
        rdchk(8'h00, 32'h41);
        autobaud_done_in <= 1'b1;
        @(posedge clk_in) autobaud_done_in <= 1'b0;
        rdchk(8'h00, 32'h40);
        flags = 0;
        apb(8'h00, 1'b1, 32'h2);
        rdchk(8'h00, 32'h42);
        @(posedge clk_in) go <= 1'b1;
        @(posedge clk_in) go <= 1'b0;
        repeat (20) @(negedge clk_in);
        chk(32'(flags), 32'h1);
        // Receiver must read idle before software retimes the link
        rdchk(8'h00, 32'h40);
        // Every mode, both polarities at random; software picks rates
        repeat (2) for (int i = 0; i < 8; i++) begin
            rate(i[2], i[1], i[0], 1'($urandom_range(0, 1)));
        end
        end_sim();
    end
    // Watchdog well beyond the expected run
    initial begin
        #900000;
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
